// ### hdl/power_mode_pkg.sv
// Package: register map, field layout, modes and carriers of the power-mode block
package power_mode_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] CTRL_OFFSET      = 5'h00;
  localparam logic [4:0] COMMAND_OFFSET   = 5'h04;
  localparam logic [4:0] WAKE_TIMER_OFFSET = 5'h08;
  localparam logic [4:0] STATUS_OFFSET    = 5'h0c;
  localparam logic [4:0] MAC_LOW_OFFSET   = 5'h10;
  localparam logic [4:0] MAC_HIGH_OFFSET  = 5'h14;
  localparam logic [4:0] MAC_SELECT_OFFSET = 5'h18;

  // Command register bit
  localparam int REBOOT_BIT = 0;

  // Address block: four addresses per unit, picked by the two low bits
  localparam int MAC_BLOCK_SIZE = 4;
  localparam logic [1:0] MAC_WLAN_SEL  = 2'h0;
  localparam logic [1:0] MAC_WIRED_SEL = 2'h1;
  localparam logic [1:0] MAC_RADIO_SEL = 2'h2;
  localparam logic [1:0] MAC_SPARE_SEL = 2'h3;
  // Arbitrary neutral base address, stands in for the production value
  localparam logic [47:0] MAC_BASE_RESET = 48'h02_00_00_00_00_00;

  // Number of GPIOs able to steer stop mode
  localparam int GPIO_COUNT = 8;

  // UART rate limit under auto clock scaling, in baud
  localparam int UART_MAX_BAUD_SCALED = 1000000;

  localparam logic [31:0] WAKE_TIMER_RESET = 32'h0000_0000;

  // Control register layout, top bit first, down to bit 0
  typedef struct packed {
    logic [22:0] unused;
    logic [2:0]  stop_gpio_select;
    logic        stop_gpio_enable;
    logic        stop_timer_enable;
    logic        stop_line_enable_command;
    logic        sleep_line_enable_command;
    logic        auto_clock_scaling;
    logic        start_in_command_mode;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '0;

  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_ACTIVE,
    MODE_STANDBY,
    MODE_SLEEP,
    MODE_STOP
  } power_mode_e;

  // Radio operating modes as reported by the radio logic
  typedef enum logic [1:0] {
    RADIO_OFF,
    RADIO_STATION,
    RADIO_ACCESS_POINT,
    RADIO_OTHER
  } radio_mode_e;

  // Status output carrier
  typedef struct packed {
    logic [2:0] mode;
    logic       cpu_full_speed;
    logic       clock_reduced;
    logic       baud_limited;
    logic       uart_deliver_enable;
    logic       connections_keep;
    logic       ram_retain;
  } power_status_s;

endpackage : power_mode_pkg

// ### hdl/module_power_mode_control.sv
// Module: reset, boot and power-mode sequencer with Avalon-MM registers
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - Keeps a block of four consecutive network addresses per unit.
// - Low two address bits: 00 wireless, 01 wired, 10 radio, 11 reserved.
// - Starts again when supply rises valid or a reset is issued.
// - In command-mode start, pulses boot-ready once booting completes.
// - No power-down input; deepest saving only through stop mode.
// - Reset pin is pulled high; low level causes full hardware reset.
// - Reboot command reboots the unit like a hardware reset.
// - Any interface activity runs the processor at full clock in active.
// - Moves between active and standby by itself.
// - Standby keeps connections and returns to active at once.
// - With auto clock scaling, internal clocks drop whenever idle.
// - With auto clock scaling, UART limited to at most 1 Mbaud.
// - Sleep keeps connections but delivers nothing on the UART.
// - With sleep line enabled, each DSR toggle enters or leaves sleep.
// - Sleep allowed only in station radio mode or radio off.
// - Stop halts everything, drops connections, keeps no RAM.
// - Every wake from stop is a full reboot.
// - With stop line enabled, each DSR toggle enters or leaves stop.
// - A configured capable GPIO toggles stop entry and exit.
// - Host-set timer wakes the unit from stop after its delay.
module module_power_mode_control (
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          resetn_i,
  // Avalon-MM slave
  input  wire logic [4:0]                    address_i,
  input  wire logic                          read_i,
  input  wire logic                          write_i,
  input  wire logic [3:0]                    byteenable_i,
  input  wire logic [31:0]                   writedata_i,
  output logic [31:0]                        readdata_o,
  output logic                               waitrequest_o,
  // Pins from outside the clock domain
  input  wire logic                          reset_pin_n_i,
  input  wire logic                          supply_good_i,
  input  wire logic                          dsr_i,
  input  wire logic [power_mode_pkg::GPIO_COUNT-1:0] gpio_i,
  // Same-domain system signals
  input  wire logic                          boot_done_i,
  input  wire logic                          activity_i,
  input  wire logic [1:0]                    radio_mode_i,
  input  wire logic [31:0]                   uart_baud_request_i,
  // Control outputs
  output logic                               system_reset_o,
  output logic                               boot_ready_msg_o,
  output logic [31:0]                        uart_baud_o,
  output logic [47:0]                        mac_wlan_o,
  output logic [47:0]                        mac_wired_o,
  output logic [47:0]                        mac_radio_o,
  output power_mode_pkg::power_status_s      status_o
);

  power_mode_pkg::ctrl_s       ctrl_reg;
  power_mode_pkg::power_mode_e mode_reg;
  power_mode_pkg::power_mode_e mode_next;
  logic [31:0] wake_delay_reg;
  logic [31:0] wake_count_reg;
  logic [47:0] mac_base_reg;
  logic [1:0]  mac_select_reg;
  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic        reboot_cmd_reg;
  logic        boot_msg_reg;
  logic        reset_pulse_reg;

  // Two-flop synchronisers for pin inputs
  logic [1:0] rst_pin_sync_reg;
  logic [1:0] supply_sync_reg;
  logic [1:0] dsr_sync_reg;
  logic [power_mode_pkg::GPIO_COUNT-1:0] gpio_meta_reg;
  logic [power_mode_pkg::GPIO_COUNT-1:0] gpio_sync_reg;
  logic        supply_last_reg;
  logic        dsr_last_reg;
  logic        gpio_last_reg;

  logic        bus_access;
  logic        write_take;
  logic        read_take;
  logic        supply_rise;
  logic        dsr_toggle;
  logic        gpio_sel_level;
  logic        gpio_toggle;
  logic        sleep_allowed;
  logic        stop_request;
  logic        sleep_request;
  logic        timer_wake;
  logic        reboot_event;

  // Pin synchronisers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_pin_sync_reg <= 2'h3;
      supply_sync_reg  <= 2'h0;
      dsr_sync_reg     <= 2'h0;
      gpio_meta_reg    <= '0;
      gpio_sync_reg    <= '0;
    end else begin
      rst_pin_sync_reg <= {rst_pin_sync_reg[0], reset_pin_n_i};
      supply_sync_reg  <= {supply_sync_reg[0], supply_good_i};
      dsr_sync_reg     <= {dsr_sync_reg[0], dsr_i};
      gpio_meta_reg    <= gpio_i;
      gpio_sync_reg    <= gpio_meta_reg;
    end
  end

  assign gpio_sel_level = gpio_sync_reg[ctrl_reg.stop_gpio_select];

  // Edge history of the synchronised lines
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      supply_last_reg <= 1'b0;
      dsr_last_reg    <= 1'b0;
      gpio_last_reg   <= 1'b0;
    end else begin
      supply_last_reg <= supply_sync_reg[1];
      dsr_last_reg    <= dsr_sync_reg[1];
      gpio_last_reg   <= gpio_sel_level;
    end
  end

  assign supply_rise = supply_sync_reg[1] & ~supply_last_reg;
  // Every edge counts once; the current mode decides enter or leave
  assign dsr_toggle  = dsr_sync_reg[1] ^ dsr_last_reg;
  assign gpio_toggle = ctrl_reg.stop_gpio_enable &
                       (gpio_sel_level ^ gpio_last_reg);

  assign sleep_allowed =
    (radio_mode_i == power_mode_pkg::RADIO_STATION) |
    (radio_mode_i == power_mode_pkg::RADIO_OFF);
  // Sleep comes only from a host line toggle
  assign sleep_request = ctrl_reg.sleep_line_enable_command & dsr_toggle &
                         sleep_allowed;
  assign stop_request  = (ctrl_reg.stop_line_enable_command & dsr_toggle) |
                         gpio_toggle;
  assign timer_wake    = ctrl_reg.stop_timer_enable &
                         (wake_count_reg >= wake_delay_reg);

  // Any of these restarts the unit from boot
  assign reboot_event =
    ~rst_pin_sync_reg[1] | supply_rise | reboot_cmd_reg |
    ((mode_reg == power_mode_pkg::MODE_STOP) &
     (stop_request | timer_wake));

  // Avalon-MM handshake: one wait cycle, answer on the second edge
  assign bus_access    = read_i | write_i;
  assign waitrequest_o = bus_access & ~ack_reg;
  assign write_take    = write_i & ack_reg;
  assign read_take     = read_i & ~ack_reg;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_access & ~ack_reg;
    end
  end

  // Write-one byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old_value,
                                        input logic [31:0] new_value,
                                        input logic [3:0]  lanes);
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return result;
  endfunction : merge

  // Configuration registers; a reboot loses them like system RAM
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg       <= power_mode_pkg::CTRL_RESET;
      wake_delay_reg <= power_mode_pkg::WAKE_TIMER_RESET;
      mac_select_reg <= power_mode_pkg::MAC_WLAN_SEL;
    end else if (reset_pulse_reg) begin
      ctrl_reg       <= power_mode_pkg::CTRL_RESET;
      wake_delay_reg <= power_mode_pkg::WAKE_TIMER_RESET;
      mac_select_reg <= power_mode_pkg::MAC_WLAN_SEL;
    end else if (write_take) begin
      case (address_i)
        power_mode_pkg::CTRL_OFFSET: begin
          ctrl_reg <= power_mode_pkg::ctrl_s'(
            merge(32'(ctrl_reg), writedata_i, byteenable_i)
            & 32'h0000_01ff);
        end
        power_mode_pkg::WAKE_TIMER_OFFSET: begin
          wake_delay_reg <= merge(wake_delay_reg, writedata_i,
                                  byteenable_i);
        end
        power_mode_pkg::MAC_SELECT_OFFSET: begin
          if (byteenable_i[0]) begin
            mac_select_reg <= writedata_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Address block stays across reboots: it lives in production memory
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mac_base_reg <= power_mode_pkg::MAC_BASE_RESET;
    end else if (write_take && address_i == power_mode_pkg::MAC_LOW_OFFSET)
    begin
      mac_base_reg[31:0] <= merge(mac_base_reg[31:0], writedata_i,
                                  byteenable_i);
    end else if (write_take &&
                 address_i == power_mode_pkg::MAC_HIGH_OFFSET) begin
      mac_base_reg[47:32] <= 16'(merge({16'h0000, mac_base_reg[47:32]},
                                       writedata_i, byteenable_i));
    end
  end

  // Reboot command, taken as a one-cycle event
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reboot_cmd_reg <= 1'b0;
    end else begin
      reboot_cmd_reg <= write_take &&
                        address_i == power_mode_pkg::COMMAND_OFFSET &&
                        byteenable_i[0] &&
                        writedata_i[power_mode_pkg::REBOOT_BIT];
    end
  end

  // Stop-mode wake timer, counts only while stopped
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_count_reg <= 32'h0000_0000;
    end else if (mode_reg != power_mode_pkg::MODE_STOP) begin
      wake_count_reg <= 32'h0000_0000;
    end else if (wake_count_reg != 32'hffff_ffff) begin
      wake_count_reg <= wake_count_reg + 32'h0000_0001;
    end
  end

  // Power-mode sequencer
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      power_mode_pkg::MODE_BOOT: begin
        if (boot_done_i) begin
          mode_next = power_mode_pkg::MODE_ACTIVE;
        end
      end
      power_mode_pkg::MODE_ACTIVE, power_mode_pkg::MODE_STANDBY: begin
        if (stop_request) begin
          mode_next = power_mode_pkg::MODE_STOP;
        end else if (sleep_request) begin
          mode_next = power_mode_pkg::MODE_SLEEP;
        end else if (activity_i) begin
          mode_next = power_mode_pkg::MODE_ACTIVE;
        end else begin
          mode_next = power_mode_pkg::MODE_STANDBY;
        end
      end
      power_mode_pkg::MODE_SLEEP: begin
        if (stop_request) begin
          mode_next = power_mode_pkg::MODE_STOP;
        end else if (ctrl_reg.sleep_line_enable_command && dsr_toggle) begin
          mode_next = activity_i ? power_mode_pkg::MODE_ACTIVE
                                 : power_mode_pkg::MODE_STANDBY;
        end
      end
      power_mode_pkg::MODE_STOP: begin
        mode_next = power_mode_pkg::MODE_STOP;
      end
      default: begin
        mode_next = power_mode_pkg::MODE_BOOT;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg        <= power_mode_pkg::MODE_BOOT;
      reset_pulse_reg <= 1'b0;
    end else if (reboot_event) begin
      mode_reg        <= power_mode_pkg::MODE_BOOT;
      reset_pulse_reg <= 1'b1;
    end else begin
      mode_reg        <= mode_next;
      reset_pulse_reg <= 1'b0;
    end
  end

  // Boot-ready message once boot ends in command-mode start
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boot_msg_reg <= 1'b0;
    end else begin
      boot_msg_reg <= !reboot_event &&
                      mode_reg == power_mode_pkg::MODE_BOOT &&
                      boot_done_i && ctrl_reg.start_in_command_mode;
    end
  end

  // Register read path, captured on the first edge of an access
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read_take) begin
      case (address_i)
        power_mode_pkg::CTRL_OFFSET:       readdata_reg <= 32'(ctrl_reg);
        power_mode_pkg::WAKE_TIMER_OFFSET: readdata_reg <= wake_delay_reg;
        power_mode_pkg::STATUS_OFFSET: begin
          readdata_reg <= {23'h000000, status_o};
        end
        power_mode_pkg::MAC_LOW_OFFSET: readdata_reg <= mac_base_reg[31:0];
        power_mode_pkg::MAC_HIGH_OFFSET: begin
          readdata_reg <= {16'h0000, mac_base_reg[47:32]};
        end
        power_mode_pkg::MAC_SELECT_OFFSET: begin
          readdata_reg <= {mac_base_reg[31:2], mac_select_reg};
        end
        default: readdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign readdata_o = readdata_reg;

  // Per-interface addresses from the low two bits of the block
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mac_wlan_o  <= '0;
      mac_wired_o <= '0;
      mac_radio_o <= '0;
    end else begin
      mac_wlan_o  <= {mac_base_reg[47:2], power_mode_pkg::MAC_WLAN_SEL};
      mac_wired_o <= {mac_base_reg[47:2], power_mode_pkg::MAC_WIRED_SEL};
      mac_radio_o <= {mac_base_reg[47:2], power_mode_pkg::MAC_RADIO_SEL};
    end
  end

  // Baud clamp: scaled clocks cannot sustain the faster rates
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uart_baud_o <= 32'h0000_0000;
    end else if (ctrl_reg.auto_clock_scaling &&
                 uart_baud_request_i >
                 32'(power_mode_pkg::UART_MAX_BAUD_SCALED)) begin
      uart_baud_o <= 32'(power_mode_pkg::UART_MAX_BAUD_SCALED);
    end else begin
      uart_baud_o <= uart_baud_request_i;
    end
  end

  // Status outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_o <= '0;
    end else begin
      status_o.mode <= mode_reg;
      status_o.cpu_full_speed <=
        mode_reg == power_mode_pkg::MODE_ACTIVE;
      status_o.clock_reduced <= ctrl_reg.auto_clock_scaling &&
        mode_reg != power_mode_pkg::MODE_ACTIVE;
      status_o.baud_limited <= ctrl_reg.auto_clock_scaling;
      status_o.uart_deliver_enable <=
        mode_reg == power_mode_pkg::MODE_ACTIVE ||
        mode_reg == power_mode_pkg::MODE_STANDBY;
      status_o.connections_keep <=
        mode_reg != power_mode_pkg::MODE_STOP &&
        mode_reg != power_mode_pkg::MODE_BOOT;
      status_o.ram_retain <= mode_reg != power_mode_pkg::MODE_STOP;
    end
  end

  assign system_reset_o   = reset_pulse_reg;
  assign boot_ready_msg_o = boot_msg_reg;

endmodule : module_power_mode_control

// ### tb/power_mode_props.sv
// Checker: bus handshake and power-mode relations seen at the block ports
`timescale 1ns/1ps
module power_mode_props (
  // Clock, reset and bus handshake
  input wire logic                          clock_i,
  input wire logic                          resetn_i,
  input wire logic                          read_i,
  input wire logic                          write_i,
  input wire logic                          waitrequest_o,
  // Observed pins
  input wire logic [1:0]                    radio_mode_i,
  input wire logic [31:0]                   uart_baud_request_i,
  input wire logic [31:0]                   uart_baud_o,
  input wire logic [47:0]                   mac_wlan_o,
  input wire logic [47:0]                   mac_wired_o,
  input wire logic [47:0]                   mac_radio_o,
  input wire logic                          system_reset_o,
  input wire logic                          boot_ready_msg_o,
  input wire power_mode_pkg::power_status_s status_o
);
  localparam logic [31:0] MAXB = 32'(power_mode_pkg::UART_MAX_BAUD_SCALED);
  logic [2:0] mode;
  assign mode = status_o.mode;
  default clocking dclk @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  a_wait_single: assert property ((read_i || write_i) && waitrequest_o
    |=> !waitrequest_o) else $error("bus wait longer than one cycle");
  a_wait_idle: assert property (!read_i && !write_i |-> !waitrequest_o)
    else $error("wait raised with no request");
  a_baud_clamp: assert property ($past(resetn_i) |->
    uart_baud_o == $past(uart_baud_request_i) || (uart_baud_o == MAXB
    && $past(uart_baud_request_i) > MAXB)) else $error("baud not clamped");
  a_mac_block: assert property ($past(resetn_i) |->
    mac_wlan_o[1:0] == 2'h0 && mac_wired_o == {mac_wlan_o[47:2], 2'h1}
    && mac_radio_o == {mac_wlan_o[47:2], 2'h2})
    else $error("address block broken");
  a_reboot_boot: assert property (system_reset_o |-> ##[0:2]
    mode == power_mode_pkg::MODE_BOOT) else $error("reboot without boot");
  a_ready_once: assert property (boot_ready_msg_o |=> !boot_ready_msg_o)
    else $error("ready message longer than a pulse");
  a_ready_active: assert property (boot_ready_msg_o |-> ##[0:1]
    mode == power_mode_pkg::MODE_ACTIVE) else $error("ready before active");
  a_active_full: assert property (status_o.cpu_full_speed ==
    (mode == power_mode_pkg::MODE_ACTIVE))
    else $error("full speed not tied to active");
  a_standby_keep: assert property (mode == power_mode_pkg::MODE_STANDBY
    |-> status_o.connections_keep) else $error("standby lost links");
  a_sleep_quiet: assert property (mode == power_mode_pkg::MODE_SLEEP
    |-> status_o.connections_keep && !status_o.uart_deliver_enable)
    else $error("sleep delivers or drops links");
  a_stop_drop: assert property (mode == power_mode_pkg::MODE_STOP
    |-> !status_o.connections_keep && !status_o.ram_retain)
    else $error("stop keeps state");
  a_sleep_radio: assert property (mode == power_mode_pkg::MODE_SLEEP
    && $past(mode) != power_mode_pkg::MODE_SLEEP |-> $past(radio_mode_i, 2)
    <= 2'h1) else $error("sleep in wrong radio mode");
endmodule : power_mode_props

bind module_power_mode_control power_mode_props u_props (
  .clock_i, .resetn_i, .read_i, .write_i, .waitrequest_o, .radio_mode_i,
  .uart_baud_request_i, .uart_baud_o, .mac_wlan_o, .mac_wired_o,
  .mac_radio_o, .system_reset_o, .boot_ready_msg_o, .status_o);

// ### tb/host_pins_model.sv
// Host model: drives DSR, GPIOs and the open-drain reset pin
`timescale 1ns/1ps
module host_pins_model (
  // Clock
  input  wire logic                                 clock_i,
  // Host-driven pins
  output logic                                      reset_pin_n_o,
  output logic                                      dsr_o,
  output logic [power_mode_pkg::GPIO_COUNT-1:0]     gpio_o
);
  logic pull_low;
  // Host only pulls low; the pull-up supplies the high level
  assign reset_pin_n_o = !pull_low;
  initial begin
    pull_low = 1'b0;
    dsr_o = 1'b0;
    gpio_o = '0;
  end
  // One edge per call, then room for the synchroniser and mode change
  task automatic toggle_dsr();
    @(posedge clock_i);
    dsr_o <= ~dsr_o;
    repeat (8) @(posedge clock_i);
  endtask : toggle_dsr
  task automatic toggle_gpio(input int idx);
    @(posedge clock_i);
    gpio_o[idx] <= ~gpio_o[idx];
    repeat (8) @(posedge clock_i);
  endtask : toggle_gpio
  task automatic pull_reset(input int cycles);
    @(posedge clock_i);
    pull_low <= 1'b1;
    repeat (cycles) @(posedge clock_i);
    pull_low <= 1'b0;
  endtask : pull_reset
endmodule : host_pins_model

// ### tb/tb_module_power_mode_control.sv
// Testbench: bus, pin and host-model scenarios for the power-mode block
`timescale 1ns/1ps
module tb_module_power_mode_control;
  logic                          clock_i, resetn_i, read_i, write_i;
  logic                          waitrequest_o, reset_pin_n_i, dsr_i;
  logic                          supply_good_i, boot_done_i, activity_i;
  logic                          system_reset_o, boot_ready_msg_o;
  logic [4:0]                    address_i;
  logic [1:0]                    radio_mode_i;
  logic [7:0]                    gpio_i;
  logic [31:0]                   writedata_i, readdata_o, v;
  logic [31:0]                   uart_baud_request_i, uart_baud_o;
  logic [47:0]                   mac_wlan_o, mac_wired_o, mac_radio_o, base;
  power_mode_pkg::power_status_s status_o;
  logic [31:0]                   exp_q[$], mask_q[$];
  int                            n_mismatch, checks, n_rst, n_msg;
  int                            r0, seed;

  module_power_mode_control u_dut (
    .clock_i, .resetn_i, .address_i, .read_i, .write_i,
    .byteenable_i(4'hf), .writedata_i, .readdata_o, .waitrequest_o,
    .reset_pin_n_i, .supply_good_i, .dsr_i, .gpio_i, .boot_done_i,
    .activity_i, .radio_mode_i, .uart_baud_request_i, .system_reset_o,
    .boot_ready_msg_o, .uart_baud_o, .mac_wlan_o, .mac_wired_o,
    .mac_radio_o, .status_o);

  host_pins_model u_host (.clock_i, .reset_pin_n_o(reset_pin_n_i),
    .dsr_o(dsr_i), .gpio_o(gpio_i));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic final_report();
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= w;
    read_i <= !w;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulses(input int n);
    repeat (10) @(posedge clock_i);
    check(48'(n_rst - r0), 48'(n));
    r0 = n_rst;
  endtask : pulses

  // Result watcher: read data and pulse counts
  always @(posedge clock_i) begin
    if (system_reset_o === 1'b1) n_rst++;
    if (boot_ready_msg_o === 1'b1) n_msg++;
    if (read_i === 1'b1 && waitrequest_o === 1'b0)
      check(48'(readdata_o & mask_q.pop_front()), 48'(exp_q.pop_front()));
  end

  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial begin
    seed = 53;
    {resetn_i, read_i, write_i, supply_good_i, boot_done_i} = '0;
    address_i = '0;
    writedata_i = '0;
    activity_i = 1'b1;
    radio_mode_i = 2'h1;
    uart_baud_request_i = 32'h0001_c200;
    {n_mismatch, checks, n_rst, n_msg, r0} = '0;
    repeat (12) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    supply_good_i <= 1'b1;
    pulses(1);
    rd(power_mode_pkg::CTRL_OFFSET, 32'h0, 32'hffff_ffff);
    rd(power_mode_pkg::MAC_HIGH_OFFSET,
       {16'h0, power_mode_pkg::MAC_BASE_RESET[47:32]}, 32'hffff_ffff);
    bus(1'b1, 5'h1c, 32'hffff_ffff);
    rd(5'h1c, 32'h0, 32'hffff_ffff);
    bus(1'b1, power_mode_pkg::CTRL_OFFSET, 32'h1);
    @(posedge clock_i);
    boot_done_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check(48'(n_msg), 48'h1);
    rd(power_mode_pkg::STATUS_OFFSET, 32'h60, 32'h1e0);
    u_host.toggle_dsr();
    rd(power_mode_pkg::STATUS_OFFSET, 32'h40, 32'h1c0);
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, power_mode_pkg::CTRL_OFFSET, {30'h0, s[0], 1'b1});
      for (int j = 0; j < 3; j++) begin
        v = j == 0 ? 32'h000f_4241 : j == 1 ? 32'h000f_4240 : $random(seed);
        @(posedge clock_i);
        uart_baud_request_i <= v;
        repeat (3) @(posedge clock_i);
        check(48'(uart_baud_o), 48'((s == 1 && v > 32'h000f_4240) ?
              32'h000f_4240 : v));
      end
    end
    @(posedge clock_i);
    activity_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd(power_mode_pkg::STATUS_OFFSET, 32'h9f, 32'h1ff);
    base[31:0] = $random(seed);
    base[47:32] = 16'($random(seed));
    bus(1'b1, power_mode_pkg::MAC_LOW_OFFSET, base[31:0]);
    bus(1'b1, power_mode_pkg::MAC_HIGH_OFFSET, {16'h0, base[47:32]});
    repeat (2) @(posedge clock_i);
    check(mac_wlan_o, {base[47:2], 2'h0});
    check(mac_wired_o, {base[47:2], 2'h1});
    check(mac_radio_o, {base[47:2], 2'h2});
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, power_mode_pkg::MAC_SELECT_OFFSET, 32'(k));
      rd(power_mode_pkg::MAC_SELECT_OFFSET, {base[31:2], 2'(k)},
         32'hffff_ffff);
    end
    // Sleep: allowed in station and radio-off, refused as access point
    bus(1'b1, power_mode_pkg::CTRL_OFFSET, 32'h6);
    u_host.toggle_dsr();
    rd(power_mode_pkg::STATUS_OFFSET, 32'hc2, 32'h1c6);
    u_host.toggle_dsr();
    rd(power_mode_pkg::STATUS_OFFSET, 32'h80, 32'h1c0);
    @(posedge clock_i);
    radio_mode_i <= 2'h2;
    u_host.toggle_dsr();
    rd(power_mode_pkg::STATUS_OFFSET, 32'h80, 32'h1c0);
    @(posedge clock_i);
    radio_mode_i <= 2'h0;
    u_host.toggle_dsr();
    rd(power_mode_pkg::STATUS_OFFSET, 32'hc2, 32'h1c6);
    u_host.toggle_dsr();
    // Stop by DSR; waking reboots and clears the configuration
    bus(1'b1, power_mode_pkg::CTRL_OFFSET, 32'h8);
    u_host.toggle_dsr();
    rd(power_mode_pkg::STATUS_OFFSET, 32'h100, 32'h1c3);
    u_host.toggle_dsr();
    pulses(1);
    rd(power_mode_pkg::CTRL_OFFSET, 32'h0, 32'hffff_ffff);
    rd(power_mode_pkg::MAC_LOW_OFFSET, base[31:0], 32'hffff_ffff);
    bus(1'b1, power_mode_pkg::CTRL_OFFSET, 32'h160);
    u_host.toggle_gpio(5);
    rd(power_mode_pkg::STATUS_OFFSET, 32'h100, 32'h1c3);
    u_host.toggle_gpio(5);
    pulses(1);
    bus(1'b1, power_mode_pkg::WAKE_TIMER_OFFSET, 32'h10);
    bus(1'b1, power_mode_pkg::CTRL_OFFSET, 32'h18);
    u_host.toggle_dsr();
    rd(power_mode_pkg::STATUS_OFFSET, 32'h100, 32'h1c3);
    repeat (12) @(posedge clock_i);
    pulses(1);
    bus(1'b1, power_mode_pkg::COMMAND_OFFSET, 32'h1);
    pulses(1);
    rd(power_mode_pkg::COMMAND_OFFSET, 32'h0, 32'hffff_ffff);
    u_host.pull_reset(4);
    repeat (10) @(posedge clock_i);
    check(48'(n_rst > r0), 48'h1);
    final_report();
  end
endmodule : tb_module_power_mode_control
